// >>> bench/iom_mux_test.sv
// self-checking bench for the io pin function multiplexer
`timescale 1ns/1ns
`include "iom_defines.svh"
module iom_mux_test;
  import iom_pkg::*;
  logic clk = 0, rst = 1;
  iom_sel_t [`IOM_NUM_PINS-1:0] func_sel = {19{3'h7}};
  iom_pin_vec_t analog_sel = '0, m_out = '0, m_oe_n = '1, ext_lvl = '0, ext_en = '1;
  iom_pin_vec_t pad_in, pad_out, pad_oe_n, m_in, a_route, a_mask;
  logic jt_sel, jt_clk, jt_di, jt_do = 0, jt_do_oe_n = 1, u_rx, u_tx = 1, cs_in;
  logic [4:0] sp_out = '0, sp_oe_n = '1, sp_in;
  logic [5:0] cs_out = '0, cs_oe_n = '1;
  int bad_count = 0, comparisons = 0;

  always #5 clk = ~clk;

  iom_pin_model pins (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext_lvl),
    .ext_en(ext_en), .pad_in(pad_in));

  iom_mux dut (.clk(clk), .rst(rst), .func_sel(func_sel), .analog_sel(analog_sel), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .matrix_out(m_out), .matrix_oe_n(m_oe_n), .matrix_in(m_in),
    .test_mode_select_in(jt_sel), .test_clock_in(jt_clk), .test_data_input(jt_di),
    .test_data_output(jt_do), .test_data_output_oe_n(jt_do_oe_n), .debug_uart_rx(u_rx), .debug_uart_tx(u_tx),
    .fast_serial_q_line_out(sp_out[0]), .fast_serial_q_line_oe_n(sp_oe_n[0]), .fast_serial_q_line_in(sp_in[0]),
    .fast_serial_d_line_out(sp_out[1]), .fast_serial_d_line_oe_n(sp_oe_n[1]), .fast_serial_d_line_in(sp_in[1]),
    .fast_serial_hold_out(sp_out[2]), .fast_serial_hold_oe_n(sp_oe_n[2]), .fast_serial_hold_in(sp_in[2]),
    .fast_serial_write_protect_out(sp_out[3]), .fast_serial_write_protect_oe_n(sp_oe_n[3]),
    .fast_serial_write_protect_in(sp_in[3]), .fast_serial_clock_out(sp_out[4]),
    .fast_serial_clock_oe_n(sp_oe_n[4]), .fast_serial_clock_in(sp_in[4]),
    .fast_serial_chip_select_out(cs_out), .fast_serial_chip_select_oe_n(cs_oe_n),
    .fast_serial_chip_select_in(cs_in), .analog_route(a_route), .analog_pin_mask(a_mask));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset;
    check("oe_n rst", pad_oe_n, 32'h7FFFF);
    check("out rst", pad_out, 32'h0);
    check("jtag in rst", {jt_sel, jt_clk, jt_di, u_rx}, 32'hF);
    check("spi in rst", {cs_in, sp_in}, 32'h3F);
    check("mtx in rst", m_in, 32'h0);
    check("mask", a_mask, 32'h61B3E);
    $display("test reset done");
  endtask : test_reset

  task automatic test_jtag;
    for (int p = 2; p <= 5; p++) func_sel[p] = 3'h0;
    jt_do = 1;
    jt_do_oe_n = 0;
    step(1);
    check("tdo out", {pad_oe_n[3], pad_out[3]}, 32'h1);
    jt_do_oe_n = 1;
    step(3);
    check("tdo tri", pad_oe_n[3], 32'h1);
    check("jtag in", {jt_sel, jt_clk, jt_di}, 32'h0);
    func_sel[4] = 3'h1;
    step(1);
    check("tck idle", jt_clk, 32'h1);
    $display("test jtag done");
  endtask : test_jtag

  task automatic test_uart;
    func_sel[14] = 3'h0;
    func_sel[15] = 3'h0;
    step(1);
    check("utx pad", {pad_oe_n[15], pad_out[15]}, 32'h1);
    u_tx = 0;
    step(3);
    check("utx low", {pad_oe_n[15], pad_out[15]}, 32'h0);
    check("urx in", u_rx, 32'h0);
    func_sel[14] = 3'h1;
    step(1);
    check("urx idle", u_rx, 32'h1);
    $display("test uart done");
  endtask : test_uart

  task automatic test_spi;
    for (int p = 0; p <= 5; p++) func_sel[p] = 3'h2;
    for (int p = 14; p <= 18; p++) func_sel[p] = 3'h2;
    sp_out = 5'h1F;
    sp_oe_n = 5'h00;
    cs_out = 6'h2B;
    cs_oe_n = 6'h00;
    step(1);
    check("spi oe", {pad_oe_n[18:14], pad_oe_n[5:0]}, 32'h0);
    check("spi out", {pad_out[18:14], pad_out[5:0]}, 32'h57F);
    sp_oe_n = 5'h1F;
    cs_oe_n = 6'h3F;
    step(4);
    check("spi tri", {pad_oe_n[18:14], pad_oe_n[5:0]}, 32'h7FF);
    check("spi in", {cs_in, sp_in}, 32'h0);
    for (int p = 0; p <= 5; p++) func_sel[p] = 3'h1;
    step(1);
    check("spi idle", {cs_in, sp_in}, 32'h3F);
    $display("test spi done");
  endtask : test_spi

  task automatic test_matrix;
    func_sel[6] = 3'h0;
    m_out[6] = 1;
    m_oe_n[6] = 0;
    func_sel[13] = 3'h1;
    m_out[13] = 1;
    m_oe_n[13] = 0;
    step(1);
    check("mtx drive", {pad_oe_n[6], pad_out[6]}, 32'h1);
    check("mtx slot1", {pad_oe_n[13], pad_out[13]}, 32'h1);
    m_oe_n[6] = 1;
    ext_lvl[6] = 1;
    step(3);
    check("mtx in", m_in[6], 32'h1);
    func_sel[6] = 3'h7;
    step(1);
    check("mtx idle", m_in[6], 32'h0);
    $display("test matrix done");
  endtask : test_matrix

  task automatic test_refuse;
    m_out[0] = 1;
    m_oe_n[0] = 0;
    func_sel[6] = 3'h2;
    cs_oe_n[3] = 0;
    for (int c = 3; c <= 7; c++) begin
      func_sel[0] = c[2:0];
      func_sel[16] = c[2:0];
      step(1);
      check("code none", {pad_oe_n[0], pad_out[0], m_in[0]}, 32'h4);
      check("spare pin", {pad_oe_n[16], pad_out[16]}, 32'h2);
      check("no slot2", pad_oe_n[6], 32'h1);
    end
    $display("test refuse done");
  endtask : test_refuse

  task automatic test_analog;
    func_sel[1] = 3'h1;
    m_out[1] = 1;
    m_oe_n[1] = 0;
    analog_sel = '1;
    step(1);
    check("route", a_route, 32'h61B3E);
    check("ana oe", pad_oe_n[1], 32'h1);
    analog_sel = '0;
    step(1);
    check("dig back", {pad_oe_n[1], pad_out[1], a_route[1]}, 32'h2);
    $display("test analog done");
  endtask : test_analog

  initial begin
    step(3);
    test_reset();
    rst = 0;
    step(1);
    test_jtag();
    test_uart();
    test_spi();
    test_matrix();
    test_refuse();
    test_analog();
    tally_and_finish();
  end

  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
endmodule : iom_mux_test

// >>> bench/iom_pin_model.sv
// board-side pin model: resolves each pad from chip drive and board drive
`timescale 1ns/1ns
module iom_pin_model (
  input  wire logic                  clk,
  input  wire iom_pkg::iom_pin_vec_t pad_out,
  input  wire iom_pkg::iom_pin_vec_t pad_oe_n,
  input  wire iom_pkg::iom_pin_vec_t ext_level,
  input  wire iom_pkg::iom_pin_vec_t ext_en,
  output iom_pkg::iom_pin_vec_t      pad_in
);
  import iom_pkg::*;
  iom_pin_vec_t float_lvl = '0;
  // undriven pads wander so a stale level never reads as valid
  always @(posedge clk) float_lvl <= ~float_lvl;
  // chip drive wins when enabled, else board, else floating
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_level)
                | (pad_oe_n & ~ext_en & float_lvl);
endmodule : iom_pin_model

// >>> hw/iom_defines.svh
// constants for the io pin function multiplexer
`ifndef IOM_DEFINES_SVH
`define IOM_DEFINES_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define IOM_NUM_PINS   19
`define IOM_NUM_SLOTS  5
`define IOM_SEL_W      3

// ----------------------------------------
// slot codes
// ----------------------------------------
`define IOM_SLOT_F0    3'h0
`define IOM_SLOT_F1    3'h1
`define IOM_SLOT_F2    3'h2
`define IOM_SEL_NONE   3'h7

// ----------------------------------------
// pin indices of direct routes
// ----------------------------------------
`define IOM_PIN_TMS    2
`define IOM_PIN_TDO    3
`define IOM_PIN_TCK    4
`define IOM_PIN_TDI    5
`define IOM_PIN_URX    14
`define IOM_PIN_UTX    15
`define IOM_PIN_CS1    14

// ----------------------------------------
// per-pin masks, bit n is pin index n
// ----------------------------------------
`define IOM_SLOT2_MASK  19'h7C03F
`define IOM_MATRIX0_MASK 19'h73FC3
`define IOM_DEF0_MASK   19'h04034
`define IOM_DEF2_MASK   19'h0003F
`define IOM_ANALOG_MASK 19'h61B3E
`define IOM_ADC_MASK    19'h0003E

// ----------------------------------------
// reset values
// ----------------------------------------
`define IOM_PAD_OUT_RST  1'b0
`define IOM_PAD_OE_N_RST 1'b1

`endif

// >>> hw/iom_mux.sv
// io pin function multiplexer top
`timescale 1ns/1ns
`include "iom_defines.svh"

module iom_mux (
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  input  wire iom_pkg::iom_sel_t [`IOM_NUM_PINS-1:0]     func_sel,
  input  wire iom_pkg::iom_pin_vec_t                     analog_sel,
  input  wire iom_pkg::iom_pin_vec_t                     pad_in,
  output iom_pkg::iom_pin_vec_t                          pad_out,
  output iom_pkg::iom_pin_vec_t                          pad_oe_n,
  input  wire iom_pkg::iom_pin_vec_t                     matrix_out,
  input  wire iom_pkg::iom_pin_vec_t                     matrix_oe_n,
  output iom_pkg::iom_pin_vec_t                          matrix_in,
  output logic                                           test_mode_select_in,
  output logic                                           test_clock_in,
  output logic                                           test_data_input,
  input  wire logic                                      test_data_output,
  input  wire logic                                      test_data_output_oe_n,
  output logic                                           debug_uart_rx,
  input  wire logic                                      debug_uart_tx,
  input  wire logic                                      fast_serial_q_line_out,
  input  wire logic                                      fast_serial_q_line_oe_n,
  output logic                                           fast_serial_q_line_in,
  input  wire logic                                      fast_serial_d_line_out,
  input  wire logic                                      fast_serial_d_line_oe_n,
  output logic                                           fast_serial_d_line_in,
  input  wire logic                                      fast_serial_hold_out,
  input  wire logic                                      fast_serial_hold_oe_n,
  output logic                                           fast_serial_hold_in,
  input  wire logic                                      fast_serial_write_protect_out,
  input  wire logic                                      fast_serial_write_protect_oe_n,
  output logic                                           fast_serial_write_protect_in,
  input  wire logic                                      fast_serial_clock_out,
  input  wire logic                                      fast_serial_clock_oe_n,
  output logic                                           fast_serial_clock_in,
  input  wire logic [5:0]                                fast_serial_chip_select_out,
  input  wire logic [5:0]                                fast_serial_chip_select_oe_n,
  output logic                                           fast_serial_chip_select_in,
  output iom_pkg::iom_pin_vec_t                          analog_route,
  output iom_pkg::iom_pin_vec_t                          analog_pin_mask
);
  import iom_pkg::*;

  localparam iom_pin_vec_t SLOT2_M   = `IOM_SLOT2_MASK;
  localparam iom_pin_vec_t MATRIX0_M = `IOM_MATRIX0_MASK;
  localparam iom_pin_vec_t DEF0_M    = `IOM_DEF0_MASK;
  localparam iom_pin_vec_t DEF2_M    = `IOM_DEF2_MASK;
  localparam iom_pin_vec_t ANALOG_M  = `IOM_ANALOG_MASK;

  iom_pin_vec_t                      pad_meta;
  iom_pin_vec_t                      pad_sync;
  iom_sel_t [`IOM_NUM_PINS-1:0]      eff_sel;
  iom_slot_vec_t [`IOM_NUM_PINS-1:0] so_out;
  iom_slot_vec_t [`IOM_NUM_PINS-1:0] so_oe_n;
  iom_slot_vec_t [`IOM_NUM_PINS-1:0] so_in;

  // ----------------------------------------
  // pad input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_meta <= '0;
      pad_sync <= '0;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // ----------------------------------------
  // analog ownership
  // ----------------------------------------
  // an analog-owned pin releases every digital slot
  always_comb begin
    for (int i = 0; i < `IOM_NUM_PINS; i++) begin
      eff_sel[i] = (analog_sel[i] && ANALOG_M[i]) ? `IOM_SEL_NONE : func_sel[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_route <= '0;
    end else begin
      analog_route <= analog_sel & ANALOG_M;
    end
  end

  assign analog_pin_mask = ANALOG_M;

  // ----------------------------------------
  // slot source table
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < `IOM_NUM_PINS; i++) begin
      so_out[i]  = {2'b00, 1'b0, matrix_out[i], matrix_out[i]};
      so_oe_n[i] = {2'b11, 1'b1, matrix_oe_n[i], matrix_oe_n[i] | ~MATRIX0_M[i]};
    end
    // jtag output takes slot zero of its pin
    so_out[`IOM_PIN_TDO][0]  = test_data_output;
    so_oe_n[`IOM_PIN_TDO][0] = test_data_output_oe_n;
    // uart transmit is output only, always driven
    so_out[`IOM_PIN_UTX][0]  = debug_uart_tx;
    so_oe_n[`IOM_PIN_UTX][0] = 1'b0;
    // fast serial on slot two
    so_out[0][2]  = fast_serial_q_line_out;
    so_oe_n[0][2] = fast_serial_q_line_oe_n;
    so_out[1][2]  = fast_serial_chip_select_out[0];
    so_oe_n[1][2] = fast_serial_chip_select_oe_n[0];
    so_out[2][2]  = fast_serial_write_protect_out;
    so_oe_n[2][2] = fast_serial_write_protect_oe_n;
    so_out[3][2]  = fast_serial_hold_out;
    so_oe_n[3][2] = fast_serial_hold_oe_n;
    so_out[4][2]  = fast_serial_clock_out;
    so_oe_n[4][2] = fast_serial_clock_oe_n;
    so_out[5][2]  = fast_serial_d_line_out;
    so_oe_n[5][2] = fast_serial_d_line_oe_n;
    for (int c = 1; c < 6; c++) begin
      so_out[`IOM_PIN_CS1 + c - 1][2]  = fast_serial_chip_select_out[c];
      so_oe_n[`IOM_PIN_CS1 + c - 1][2] = fast_serial_chip_select_oe_n[c];
    end
  end

  // ----------------------------------------
  // pad cells
  // ----------------------------------------
  for (genvar g = 0; g < `IOM_NUM_PINS; g++) begin : g_pin
    iom_pin_cell #(
      .HAS_SLOT   ({2'b00, SLOT2_M[g], 2'b11}),
      .IN_DEFAULT ({2'b00, DEF2_M[g], 1'b0, DEF0_M[g]})
    ) u_cell (
      .clk       (clk),
      .rst       (rst),
      .sel       (eff_sel[g]),
      .slot_out  (so_out[g]),
      .slot_oe_n (so_oe_n[g]),
      .pad_in    (pad_sync[g]),
      .pad_out   (pad_out[g]),
      .pad_oe_n  (pad_oe_n[g]),
      .slot_in   (so_in[g])
    );
    // matrix inputs default low when the pin is elsewhere
    assign matrix_in[g] = so_in[g][1] | (so_in[g][0] & MATRIX0_M[g]);
  end

  // ----------------------------------------
  // direct peripheral inputs
  // ----------------------------------------
  assign test_mode_select_in          = so_in[`IOM_PIN_TMS][0];
  assign test_clock_in                = so_in[`IOM_PIN_TCK][0];
  assign test_data_input              = so_in[`IOM_PIN_TDI][0];
  assign debug_uart_rx                = so_in[`IOM_PIN_URX][0];
  assign fast_serial_q_line_in        = so_in[0][2];
  assign fast_serial_chip_select_in   = so_in[1][2];
  assign fast_serial_write_protect_in = so_in[2][2];
  assign fast_serial_hold_in          = so_in[3][2];
  assign fast_serial_clock_in         = so_in[4][2];
  assign fast_serial_d_line_in        = so_in[5][2];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  one_slot_drive_a: assert property (!pad_oe_n[0] |-> $past(eff_sel[0]) <= 3'h2)
    else $error("pin 0 driven without a valid slot");
  tms_default_high_a: assert property ($past(eff_sel[2]) != 3'h0 |-> test_mode_select_in)
    else $error("tms not high while unselected");
  matrix_in_low_a: assert property ($past(eff_sel[0]) > 3'h1 |-> !matrix_in[0])
    else $error("matrix input not low while unselected");
  tdo_tristate_a: assert property ($past(eff_sel[3]) == 3'h0 |->
                                   pad_oe_n[3] == $past(test_data_output_oe_n))
    else $error("tdo enable not followed");
  matrix_route_a: assert property ($past(eff_sel[13]) == 3'h1 |->
                                   pad_out[13] == $past(matrix_out[13]) &&
                                   pad_oe_n[13] == $past(matrix_oe_n[13]))
    else $error("matrix slot not routed");
  tck_direct_a: assert property ($past(eff_sel[4]) == 3'h0 |-> test_clock_in == $past(pad_sync[4]))
    else $error("tck not taken from pad");
  tck_path_a: assert property ($past(func_sel[4]) == 3'h0 && !$past(analog_sel[4]) |->
                               test_clock_in == $past(pad_in[4], 3))
    else $error("tck latency not three cycles");
  uart_tx_drive_a: assert property ($past(eff_sel[15]) == 3'h0 |->
                                    !pad_oe_n[15] && pad_out[15] == $past(debug_uart_tx))
    else $error("uart transmit not driven");
  spi_cs5_a: assert property ($past(eff_sel[18]) == 3'h2 |->
                              pad_out[18] == $past(fast_serial_chip_select_out[5]))
    else $error("chip select five not routed");
  analog_release_a: assert property (analog_sel[1] |=> pad_oe_n[1] && analog_route[1])
    else $error("analog pin not released");
  spare_code_a: assert property ($past(eff_sel[16]) inside {3'h3, 3'h4} |->
                                 pad_oe_n[16] ##0 !pad_out[16])
    else $error("spare slot code connected something");
  urx_default_high_a: assert property ($past(eff_sel[14]) != 3'h0 |-> debug_uart_rx)
    else $error("uart receive not high while unselected");
  tdi_default_high_a: assert property ($past(eff_sel[5]) != 3'h0 |-> test_data_input)
    else $error("tdi not high while unselected");
  cs1_tristate_a: assert property ($past(eff_sel[14]) == 3'h2 |->
                                  pad_oe_n[14] == $past(fast_serial_chip_select_oe_n[1]))
    else $error("chip select one enable not followed");

  jtag_sel_c: cover property (eff_sel[4] == 3'h0 ##1 eff_sel[4] == 3'h1);
  spi_sel_c: cover property (eff_sel[0] == 3'h2 ##1 !pad_oe_n[0]);
  analog_c: cover property (analog_sel[17] ##1 analog_route[17]);
  spare_c: cover property (eff_sel[16] == 3'h3 ##1 pad_oe_n[16]);
  uart_c: cover property (eff_sel[15] == 3'h0 ##1 !pad_oe_n[15]);
endmodule : iom_mux

// >>> hw/iom_pin_cell.sv
// one pad: slot select, pad drive and per-slot input defaults
`timescale 1ns/1ns
`include "iom_defines.svh"

module iom_pin_cell #(
  parameter iom_pkg::iom_slot_vec_t HAS_SLOT   = 5'h03,
  parameter iom_pkg::iom_slot_vec_t IN_DEFAULT = 5'h00
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire iom_pkg::iom_sel_t      sel,
  input  wire iom_pkg::iom_slot_vec_t slot_out,
  input  wire iom_pkg::iom_slot_vec_t slot_oe_n,
  input  wire logic                   pad_in,
  output logic                        pad_out,
  output logic                        pad_oe_n,
  output iom_pkg::iom_slot_vec_t      slot_in
);
  import iom_pkg::*;

  iom_slot_vec_t hit;

  // at most one slot hits; codes without a slot hit nothing
  always_comb begin
    for (int k = 0; k < `IOM_NUM_SLOTS; k++) begin
      hit[k] = HAS_SLOT[k] && (sel == 3'(k));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out  <= `IOM_PAD_OUT_RST;
      pad_oe_n <= `IOM_PAD_OE_N_RST;
    end else begin
      pad_out  <= |(hit & slot_out);
      pad_oe_n <= ~|(hit & ~slot_oe_n);
    end
  end

  // unselected slots see their fixed default level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_in <= IN_DEFAULT;
    end else begin
      slot_in <= (hit & {`IOM_NUM_SLOTS{pad_in}}) | (~hit & IN_DEFAULT);
    end
  end
endmodule : iom_pin_cell

// >>> hw/iom_pkg.sv
// types for the io pin function multiplexer
`include "iom_defines.svh"

package iom_pkg;
  typedef logic [`IOM_SEL_W-1:0]     iom_sel_t;
  typedef logic [`IOM_NUM_SLOTS-1:0] iom_slot_vec_t;
  typedef logic [`IOM_NUM_PINS-1:0]  iom_pin_vec_t;
endpackage : iom_pkg
